// *** drtp_pkg.sv ***
// register map and field constants of the dual reload timer pwm block
package drtp_pkg;
   // register indices; byte address is index times four
   localparam logic [7:0] IDX_A_MODE = 8'hda;
   localparam logic [7:0] IDX_A_CNT  = 8'hdb;
   localparam logic [7:0] IDX_A_RLD  = 8'hcd;
   localparam logic [7:0] IDX_A_DUTY = 8'he8;
   localparam logic [7:0] IDX_B_MODE = 8'hdc;
   localparam logic [7:0] IDX_B_CNT  = 8'hdd;
   localparam logic [7:0] IDX_B_RLD  = 8'hde;
   localparam logic [7:0] IDX_B_DUTY = 8'hea;
   localparam logic [7:0] IDX_IRQ_EN = 8'hf0;
   localparam logic [7:0] IDX_STAT   = 8'hf1;
   // mode register fields
   localparam int MODE_EN    = 7;
   localparam int MODE_RATE  = 4;
   localparam int MODE_EXT   = 3;
   localparam int MODE_CKS   = 2;
   localparam int MODE_PWM   = 0;
   localparam logic [7:0] MODE_A_MASK = 8'hfd;
   localparam logic [7:0] MODE_B_MASK = 8'hf5;
   // status and enable fields
   localparam int ST_A_OVF = 0;
   localparam int ST_B_OVF = 1;
   localparam int ST_EXT   = 2;
   // reset values and fixed figures
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] FULL_CNT  = 8'hff;
   localparam logic [6:0] PRE_MASK  = 7'h7f;
   localparam logic [7:0] TMR_VEC   = 8'h08;
   localparam int         FCPU_DIV  = 2;
endpackage

// *** drtp_top.sv ***
// two auto-reload 8-bit timers with pwm, event counting and apb registers
//
// Overview of operation
// - ext select 1 clocks timer a from pin
// - only falling event edges add exactly one
// - timer a wrap from ff to the reload value raises overflow
// - event mode blocks pin wake-up
// - event mode blocks pin irq, flag zero
// - timer a pwm only when enabled and selected
// - pwm period starts high, ends low
// - reload loaded on enable and every overflow
// - pwm drops when count equals duty
// - overflow ends period, output returns high
// - new reload applies from next period
// - duty not above reload keeps pwm low
// - overflow flag and irq also under pwm
// - pwm off returns pin to gpio
// - timer b counts only while enabled
// - timer b wrap sets sticky overflow flag
// - auto reload always on, no control
// - timer irq gives vector address eight
// - green mode keeps timers running, no wake
// - prescaler 128 down to 1, or raw clock
// - timer b mode fields, reset zero
// - ext select routes pin as count clock
// - timer b pwm same scheme own pin
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module drtp_top
   import drtp_pkg::*;
#(
   parameter int FCPU_DIVIDE = drtp_pkg::FCPU_DIV
)
(
   // clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RST_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [9:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // pins and gpio state
   input  wire logic        EVENT_PIN_I,
   input  wire logic        GPIO_A_DATA_I,
   input  wire logic        GPIO_A_OE_I,
   input  wire logic        GPIO_B_DATA_I,
   input  wire logic        GPIO_B_OE_I,
   output logic             PWM_A_O,
   output logic             PWM_A_OE_O,
   output logic             PWM_B_O,
   output logic             PWM_B_OE_O,
   // system side
   input  wire logic        GREEN_MODE_I,
   output logic             TIMER_A_IRQ_O,
   output logic             TIMER_B_IRQ_O,
   output logic             EXT_PIN_IRQ_O,
   output logic [7:0]       IRQ_VECTOR_O,
   output logic             WAKE_O
);
   import drtp_pkg::*;

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   // apb decode
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [31:0] rd_next;
   logic        hit_next;
   wire  [7:0]  idx    = PADDR_I[9:2];
   wire         setup  = PSEL_I & ~PENABLE_I;
   wire         wr     = PSEL_I & PENABLE_I & PWRITE_I & pready_reg;
   wire  [7:0]  wdat   = PWDATA_I[7:0];

   // shared state
   logic [7:0]  mode_reg [2];
   logic [7:0]  cnt_reg  [2];
   logic [7:0]  rld_reg  [2];
   logic [7:0]  cur_reg  [2];
   logic [7:0]  duty_reg [2];
   logic        pwm_reg  [2];
   logic        en_d_reg [2];
   logic        pin_reg  [2];
   logic        oe_reg   [2];
   logic [1:0]  ovf;
   logic [1:0]  tick;
   logic [1:0]  load;
   logic [2:0]  stat_reg;
   logic [2:0]  irqen_reg;
   wire         evt_mode = mode_reg[0][MODE_EXT];

   // fcpu enable and shared prescaler
   logic [7:0] fdiv_reg;
   logic [6:0] pre_reg;
   wire        fcpu_en = (fdiv_reg == 8'(FCPU_DIVIDE - 1));

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         fdiv_reg <= 8'h00;
         pre_reg  <= 7'h00;
      end
      else
      begin
         fdiv_reg <= fcpu_en ? 8'h00 : fdiv_reg + 8'h01;
         if (fcpu_en)
            pre_reg <= pre_reg + 7'h01;
      end
   end

   // event pin: three stages, change taken when stages two and three agree
   logic s1_reg, s2_reg, s3_reg, lvl_reg;
   wire  agree    = (s2_reg == s3_reg);
   wire  pin_fall = agree & lvl_reg & ~s3_reg;
   wire  pin_chg  = agree & (lvl_reg != s3_reg);

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         s1_reg  <= 1'b1;
         s2_reg  <= 1'b1;
         s3_reg  <= 1'b1;
         lvl_reg <= 1'b1;
      end
      else
      begin
         s1_reg <= EVENT_PIN_I;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (agree)
            lvl_reg <= s3_reg;
      end
   end

   wire [1:0] gpio_d  = {GPIO_B_DATA_I, GPIO_A_DATA_I};
   wire [1:0] gpio_oe = {GPIO_B_OE_I, GPIO_A_OE_I};

   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_tmr
         localparam logic [7:0] MI = (i == 0) ? IDX_A_MODE : IDX_B_MODE;
         localparam logic [7:0] CI = (i == 0) ? IDX_A_CNT : IDX_B_CNT;
         localparam logic [7:0] RI = (i == 0) ? IDX_A_RLD : IDX_B_RLD;
         localparam logic [7:0] DI = (i == 0) ? IDX_A_DUTY : IDX_B_DUTY;
         localparam logic [7:0] MM = (i == 0) ? MODE_A_MASK : MODE_B_MASK;
         wire       en     = mode_reg[i][MODE_EN];
         wire       ext    = (i == 0) & mode_reg[i][MODE_EXT];
         wire [2:0] rate   = mode_reg[i][MODE_RATE +: 3];
         wire [6:0] msk    = PRE_MASK >> rate;
         wire       pre_tk = fcpu_en & ((pre_reg & msk) == msk);
         wire       raw_tk = ext ? pin_fall :
                             (mode_reg[i][MODE_CKS] ? 1'b1 : pre_tk);
         wire       en_up  = en & ~en_d_reg[i];
         wire       wr_m   = wr & (idx == MI);
         wire       wr_c   = wr & (idx == CI);
         wire       wr_r   = wr & (idx == RI);
         wire       wr_d   = wr & (idx == DI);
         wire       run    = en & pwm_reg[i] & mode_reg[i][MODE_PWM];

         assign tick[i] = en & raw_tk;
         assign ovf[i]  = tick[i] & (cnt_reg[i] == FULL_CNT);
         assign load[i] = ovf[i] | en_up;

         always_ff @(posedge CLOCK_I)
         begin
            if (RST_I)
            begin
               mode_reg[i] <= RST_BYTE;
               cnt_reg[i]  <= RST_BYTE;
               rld_reg[i]  <= RST_BYTE;
               cur_reg[i]  <= RST_BYTE;
               duty_reg[i] <= RST_BYTE;
               pwm_reg[i]  <= 1'b0;
               en_d_reg[i] <= 1'b0;
               pin_reg[i]  <= 1'b0;
               oe_reg[i]   <= 1'b0;
            end
            else
            begin
               en_d_reg[i] <= en;
               if (wr_m)
                  mode_reg[i] <= wdat & MM;
               if (wr_r)
                  rld_reg[i] <= wdat;
               if (wr_d)
                  duty_reg[i] <= wdat;
               // software write of the count wins over a tick
               if (wr_c)
                  cnt_reg[i] <= wdat;
               else if (load[i])
                  cnt_reg[i] <= rld_reg[i];
               else if (tick[i])
                  cnt_reg[i] <= cnt_reg[i] + 8'h01;
               if (load[i])
               begin
                  cur_reg[i] <= rld_reg[i];
                  pwm_reg[i] <= duty_reg[i] > rld_reg[i];
               end
               else if (en & (cnt_reg[i] == duty_reg[i]))
                  pwm_reg[i] <= 1'b0;
               // pin mux: pwm while enabled and selected, else gpio
               pin_reg[i] <= (en & mode_reg[i][MODE_PWM]) ? pwm_reg[i]
                             : gpio_d[i];
               oe_reg[i]  <= (en & mode_reg[i][MODE_PWM]) | gpio_oe[i];
            end
         end

         // assertions for this timer
         sequence s_load_dut;
            load[i] && !wr_c && !wr_d;
         endsequence

         a_reload_load: assert property (
            s_load_dut |=> cnt_reg[i] == $past(rld_reg[i]))
            else $error("count not reloaded");
         a_pwm_start_hi: assert property (
            s_load_dut and (duty_reg[i] > rld_reg[i]) |=> pwm_reg[i])
            else $error("pwm period did not start high");
         a_bad_duty_low: assert property (
            s_load_dut and (duty_reg[i] <= rld_reg[i]) |=> !pwm_reg[i])
            else $error("pwm high with duty not above reload");
         a_pwm_eq_low: assert property (
            en && !load[i] && cnt_reg[i] == duty_reg[i] |=> !pwm_reg[i])
            else $error("pwm not low at duty match");
         a_stop_hold: assert property (
            !en && !wr_c && !en_d_reg[i] |=> $stable(cnt_reg[i]))
            else $error("stopped timer counted");
         a_pin_pwm: assert property (
            en && mode_reg[i][MODE_PWM] |=> pin_reg[i] == $past(pwm_reg[i]))
            else $error("pin does not carry pwm");
         a_pin_gpio: assert property (
            !(en && mode_reg[i][MODE_PWM]) |=> pin_reg[i] == $past(gpio_d[i]))
            else $error("pin not back to gpio");
         a_ovf_flag: assert property (
            ovf[i] |=> stat_reg[i])
            else $error("overflow flag not set");
         a_wrap_period: assert property (
            run && !load[i] ##1 load[i] |=> pwm_reg[i] || duty_reg[i] <= cur_reg[i]
            || $past(duty_reg[i]) <= $past(rld_reg[i]))
            else $error("period did not restart high");
      end
   endgenerate

   // flags: hardware set wins over a software clear
   wire [2:0] clr   = (wr & (idx == IDX_STAT)) ? wdat[2:0] : 3'b000;
   wire [2:0] irq_n = {stat_reg[ST_EXT] & irqen_reg[ST_EXT],
                       stat_reg[ST_B_OVF] & irqen_reg[ST_B_OVF],
                       stat_reg[ST_A_OVF] & irqen_reg[ST_A_OVF]};

   logic tirq_a_reg, tirq_b_reg, eirq_reg, wake_reg;
   logic [7:0] vec_reg;

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         stat_reg   <= 3'b000;
         irqen_reg  <= 3'b000;
         tirq_a_reg <= 1'b0;
         tirq_b_reg <= 1'b0;
         eirq_reg   <= 1'b0;
         vec_reg    <= RST_BYTE;
         wake_reg   <= 1'b0;
      end
      else
      begin
         if (wr & (idx == IDX_IRQ_EN))
            irqen_reg <= wdat[2:0];
         stat_reg[1:0] <= (stat_reg[1:0] & ~clr[1:0]) | ovf;
         stat_reg[ST_EXT] <= evt_mode ? 1'b0
                             : (stat_reg[ST_EXT] & ~clr[ST_EXT]) | pin_fall;
         tirq_a_reg <= irq_n[0];
         tirq_b_reg <= irq_n[1];
         eirq_reg   <= irq_n[2] & ~evt_mode;
         vec_reg    <= (irq_n[0] | irq_n[1]) ? TMR_VEC : RST_BYTE;
         // only the pin wakes; timers never do in green mode
         wake_reg   <= GREEN_MODE_I & pin_chg & ~evt_mode;
      end
   end

   // apb read mux, answered with one access cycle
   always_comb
   begin
      rd_next  = 32'h0000_0000;
      hit_next = 1'b1;
      case (idx)
         IDX_A_MODE: rd_next[7:0] = mode_reg[0];
         IDX_A_CNT:  rd_next[7:0] = cnt_reg[0];
         IDX_A_DUTY: rd_next[7:0] = duty_reg[0];
         IDX_B_MODE: rd_next[7:0] = mode_reg[1];
         IDX_B_CNT:  rd_next[7:0] = cnt_reg[1];
         IDX_B_DUTY: rd_next[7:0] = duty_reg[1];
         IDX_A_RLD:  rd_next[7:0] = RST_BYTE;
         IDX_B_RLD:  rd_next[7:0] = RST_BYTE;
         IDX_IRQ_EN: rd_next[2:0] = irqen_reg;
         IDX_STAT:   rd_next[2:0] = stat_reg;
         default:    hit_next     = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= setup;
         prdata_reg  <= (setup & ~PWRITE_I) ? rd_next : 32'h0000_0000;
         pslverr_reg <= setup & ~hit_next;
      end
   end

   // system-level assertions
   a_evt_count: assert property (
      evt_mode && tick[0] && !load[0] && !g_tmr[0].wr_c
      |=> cnt_reg[0] == $past(cnt_reg[0]) + 8'h01)
      else $error("event edge not counted once");
   a_evt_only_fall: assert property (
      evt_mode && !pin_fall |-> !tick[0])
      else $error("timer a ticked without falling edge");
   a_ext_flag_zero: assert property (
      evt_mode |=> !stat_reg[ST_EXT] && !EXT_PIN_IRQ_O)
      else $error("pin irq flag set in event mode");
   a_no_wake_evt: assert property (
      evt_mode |=> !WAKE_O)
      else $error("event pin woke system");
   a_irq_vector: assert property (
      irq_n[1] |=> TIMER_B_IRQ_O && IRQ_VECTOR_O == TMR_VEC)
      else $error("timer b irq without vector");
   a_apb_ready: assert property (
      setup |=> PREADY_O ##1 !PREADY_O)
      else $error("apb answer not one cycle");

   assign PRDATA_O      = prdata_reg;
   assign PREADY_O      = pready_reg;
   assign PSLVERR_O     = pslverr_reg;
   assign PWM_A_O       = pin_reg[0];
   assign PWM_A_OE_O    = oe_reg[0];
   assign PWM_B_O       = pin_reg[1];
   assign PWM_B_OE_O    = oe_reg[1];
   assign TIMER_A_IRQ_O = tirq_a_reg;
   assign TIMER_B_IRQ_O = tirq_b_reg;
   assign EXT_PIN_IRQ_O = eirq_reg;
   assign IRQ_VECTOR_O  = vec_reg;
   assign WAKE_O        = wake_reg;
endmodule

// *** drtp_partner.sv ***
// far side model: event pulse source and a pwm load that times the pin
`timescale 1ns/1ns
module drtp_partner
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // event source
   input  wire logic       ev_go_i,
   input  wire logic [7:0] ev_num_i,
   output logic            event_o,
   output logic            ev_busy_o,
   // pwm load
   input  wire logic       pin_i,
   input  wire logic       oe_i,
   output logic [7:0]      hi_o,
   output logic [7:0]      per_o
);
   logic       seen_q;
   logic       level;
   logic [7:0] hi_run;
   logic [7:0] per_run;
   // an undriven pin reads low, as through the load's pull-down
   assign level = pin_i & oe_i;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         seen_q  <= 1'b0;
         per_run <= 8'h00;
         hi_run  <= 8'h00;
         per_o   <= 8'h00;
         hi_o    <= 8'h00;
      end
      else
      begin
         seen_q <= level;
         if (level && !seen_q)
         begin
            per_o   <= per_run;
            hi_o    <= hi_run;
            per_run <= 8'h01;
            hi_run  <= 8'h01;
         end
         else
         begin
            per_run <= per_run + 8'h01;
            hi_run  <= hi_run + {7'h00, level};
         end
      end
   end
   // idle line rests high on its pull-up; each level held 3 clocks for the synchroniser
   initial
   begin
      event_o   = 1'b1;
      ev_busy_o = 1'b0;
      forever
      begin
         @(posedge clk_i);
         if (ev_go_i)
         begin
            ev_busy_o <= 1'b1;
            for (int i = 0; i < int'(ev_num_i); i++)
            begin
               event_o <= 1'b0;
               repeat (3) @(posedge clk_i);
               event_o <= 1'b1;
               repeat (3) @(posedge clk_i);
            end
            ev_busy_o <= 1'b0;
         end
      end
   end
endmodule

// *** drtp_top_tb.sv ***
// self-checking bench for the two-timer pwm block
`timescale 1ns/1ns
module drtp_top_tb;
   import drtp_pkg::*;
   typedef struct {logic b; logic [7:0] mode, rld, duty, per, hi;} drtp_row_s;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwd = '0, prd, q;
   logic        prdy, perr, e, ev, busy, ev_go = 1'b0, green = 1'b0;
   logic        gd = 1'b0, goe = 1'b0, bad = 1'b0, watch = 1'b0, woke = 1'b0;
   logic        pa, pa_oe, pb, pb_oe, irq_a, irq_b, irq_x, wake;
   logic [7:0]  vec, hi_a, per_a, hi_b, per_b, m;
   int          mismatches = 0;
   int          tests_run = 0;
   // timer, mode, reload, duty, period and high time in clocks
   drtp_row_s   rows [4] = '{'{1'b0, 8'h05, 8'hf0, 8'hf8, 8'h10, 8'h09},
                             '{1'b1, 8'h05, 8'he0, 8'he1, 8'h20, 8'h02},
                             '{1'b1, 8'h71, 8'hf0, 8'hf8, 8'h20, 8'h11},
                             '{1'b0, 8'h61, 8'hf8, 8'hfa, 8'h20, 8'h09}};
   logic [7:0]  ridx [8] = '{IDX_A_MODE, IDX_A_CNT, IDX_A_RLD, IDX_A_DUTY,
                             IDX_B_MODE, IDX_B_CNT, IDX_B_DUTY, IDX_STAT};

   always #2 clk = ~clk;

   drtp_top #(.FCPU_DIVIDE(2)) u_drtp_top
   (
      .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .EVENT_PIN_I(ev), .GPIO_A_DATA_I(gd), .GPIO_A_OE_I(goe),
      .GPIO_B_DATA_I(gd), .GPIO_B_OE_I(goe), .PWM_A_O(pa), .PWM_A_OE_O(pa_oe),
      .PWM_B_O(pb), .PWM_B_OE_O(pb_oe), .GREEN_MODE_I(green), .TIMER_A_IRQ_O(irq_a),
      .TIMER_B_IRQ_O(irq_b), .EXT_PIN_IRQ_O(irq_x), .IRQ_VECTOR_O(vec), .WAKE_O(wake)
   );
   drtp_partner u_part_a
   (
      .clk_i(clk), .rst_i(rst), .ev_go_i(ev_go), .ev_num_i(8'd3), .event_o(ev),
      .ev_busy_o(busy), .pin_i(pa), .oe_i(pa_oe), .hi_o(hi_a), .per_o(per_a)
   );
   drtp_partner u_part_b
   (
      .clk_i(clk), .rst_i(rst), .ev_go_i(1'b0), .ev_num_i(8'd0), .event_o(),
      .ev_busy_o(), .pin_i(pb), .oe_i(pb_oe), .hi_o(hi_b), .per_o(per_b)
   );

   always @(posedge clk)
      if (watch && (wake === 1'b1 || irq_x === 1'b1))
         bad <= 1'b1;
   // wake is a one-cycle pulse, so keep it for the later check
   always @(posedge clk)
      if (!watch && wake === 1'b1)
         woke <= 1'b1;

   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, x, g);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task burst;
      ev_go <= 1'b1;
      tick(1);
      ev_go <= 1'b0;
      tick(2);
      for (int k = 0; k < 100 && busy !== 1'b0; k++)
         tick(1);
      tick(8);
   endtask
   task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel  <= 1'b1;
      pwr   <= w;
      paddr <= {i, 2'b00};
      pwd   <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (prdy !== 1'b1);
      chk("pready wait", 32'h1, n);
      q = prd;
      e = perr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask
   task rd(input logic [7:0] i, input logic [7:0] x, input string n);
      apb(1'b0, i, 8'h00);
      chk(n, {24'h0, x}, q);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (6000) @(posedge clk);
      $display("Error watchdog expected done seen hang");
      mismatches++;
      conclude;
   end

   initial
   begin
      tick(3);
      rst <= 1'b0;
      foreach (rows[r])
      begin
         m = rows[r].b ? IDX_B_MODE : IDX_A_MODE;
         gd  <= 1'(r % 2);
         goe <= 1'b1;
         wr(m, rows[r].mode);
         wr(m + 8'h01, rows[r].rld);
         wr(rows[r].b ? IDX_B_RLD : IDX_A_RLD, rows[r].rld);
         wr(rows[r].b ? IDX_B_DUTY : IDX_A_DUTY, rows[r].duty);
         wr(IDX_IRQ_EN, 8'h03);
         wr(m, rows[r].mode | 8'h80);
         tick(120);
         chk("period", rows[r].per, rows[r].b ? per_b : per_a);
         chk("high time", rows[r].hi, rows[r].b ? hi_b : hi_a);
         chk("timer irq", 32'h1, rows[r].b ? irq_b : irq_a);
         chk("irq vector", 32'h8, vec);
         wr(m, 8'h80 | (rows[r].mode & 8'hfe));
         tick(2);
         chk("gpio pin", {gd, goe}, rows[r].b ? {pb, pb_oe} : {pa, pa_oe});
         wr(m, 8'h00);
         wr(IDX_STAT, 8'h03);
         $display("test pwm row %0d done", r);
      end
      rst <= 1'b1;
      tick(2);
      chk("outputs in reset", 0, {pa, pa_oe, pb, pb_oe, irq_a, irq_b, irq_x, wake, vec});
      tick(1);
      rst <= 1'b0;
      foreach (ridx[k])
         rd(ridx[k], 8'h00, "reset value");
      wr(IDX_B_MODE, 8'h7f);
      rd(IDX_B_MODE, 8'h75, "mode b fields");
      apb(1'b0, 8'h00, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, e});
      $display("test reset and map done");
      wr(IDX_B_CNT, 8'h10);
      wr(IDX_B_MODE, 8'h04);
      tick(20);
      rd(IDX_B_CNT, 8'h10, "stopped count");
      wr(IDX_IRQ_EN, 8'h02);
      wr(IDX_B_RLD, 8'hfc);
      wr(IDX_B_MODE, 8'h84);
      tick(10);
      wr(IDX_B_MODE, 8'h04);
      tick(20);
      rd(IDX_STAT, 8'h02, "sticky flag");
      chk("irq b", 32'h1, {31'h0, irq_b});
      wr(IDX_STAT, 8'h02);
      rd(IDX_STAT, 8'h00, "flag cleared");
      $display("test stop and flag done");
      wr(IDX_B_CNT, 8'h00);
      wr(IDX_B_RLD, 8'h00);
      wr(IDX_B_MODE, 8'h84);
      wr(IDX_B_RLD, 8'hf0);
      apb(1'b0, IDX_B_CNT, 8'h00);
      chk("current period", 32'h1, {31'h0, q[7:0] < 8'hf0});
      tick(260);
      apb(1'b0, IDX_B_CNT, 8'h00);
      chk("next period", 32'h1, {31'h0, q[7:0] >= 8'hf0});
      wr(IDX_B_MODE, 8'h00);
      $display("test reload buffer done");
      wr(IDX_A_MODE, 8'h08);
      wr(IDX_A_CNT, 8'hfe);
      wr(IDX_A_RLD, 8'hfe);
      wr(IDX_STAT, 8'h07);
      wr(IDX_IRQ_EN, 8'h05);
      green <= 1'b1;
      watch <= 1'b1;
      wr(IDX_A_MODE, 8'h88);
      burst;
      rd(IDX_A_CNT, 8'hff, "event count");
      rd(IDX_STAT, 8'h01, "event flags");
      chk("irq a", 32'h1, {31'h0, irq_a});
      chk("wake or pin irq", 32'h0, {31'h0, bad});
      $display("test event counter done");
      // same pulses with event mode off must flag, interrupt and wake
      watch <= 1'b0;
      wr(IDX_A_MODE, 8'h00);
      wr(IDX_STAT, 8'h07);
      burst;
      rd(IDX_STAT, 8'h04, "pin flag");
      chk("pin irq", 32'h1, {31'h0, irq_x});
      chk("pin wake", 32'h1, {31'h0, woke});
      $display("test pin irq done");
      conclude;
   end
endmodule
